// *** core/rsis_sequencer.sv ***
`timescale 1ns/100ps
module rsis_sequencer #(
  parameter int HOLD_CYC = rsis_pkg::HOLD_CYC_DEF,
  parameter int PRST_CYC = rsis_pkg::PRST_CYC_DEF
) (
  // Clock and reset
  input  wire logic        SYS_CLK_I,
  input  wire logic        RST_B_I,
  // APB slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // Contact inputs, high means shorted
  input  wire logic        AUTO_ENABLE_I,
  input  wire logic        PREP_START_I,
  input  wire logic        MOTOR_REQ_I,
  input  wire logic        CAL_REQ_I,
  input  wire logic        FULL_SPEED_REQUEST_I,
  input  wire logic        EXT_MODE_REQ_I,
  input  wire logic        PROG_RESET_REQ_I,
  input  wire logic        CLEAR_FAIL_I,
  input  wire logic        PROG_START_I,
  input  wire logic        PROG_PARITY_I,
  input  wire logic [7:0]  PROG_SEL_I,
  // Status outputs
  output logic             POWER_ON_COMPLETE_O,
  output logic             AUTO_MODE_O,
  output logic             EXT_MODE_O,
  output logic             MANUAL_OK_O,
  output logic             MOTOR_ON_O,
  output logic             CAL_DONE_O,
  output logic             FULL_SPEED_O,
  output logic             PROG_INIT_O,
  output logic             PROG_RUN_O,
  output logic      [7:0]  PROG_NUM_O,
  output logic             ERROR_VALID_O,
  output logic      [15:0] ERROR_CODE_O
);

  localparam int PIN_W = $bits(rsis_pkg::rsis_pins_t);

  logic [PIN_W-1:0]       raw_pins;
  logic [PIN_W-1:0]       deb_pins;
  rsis_pkg::rsis_pins_t   pins;
  rsis_pkg::rsis_pins_t   pins_q;
  rsis_pkg::rsis_mode_t   mode;
  rsis_pkg::rsis_mode_t   next_mode;
  rsis_pkg::rsis_seq_t    seq;
  rsis_pkg::rsis_seq_t    next_seq;
  rsis_pkg::rsis_err_t    err;
  rsis_pkg::rsis_err_t    next_err;
  logic [1:0]             sel;
  logic                   pendant;
  logic [4:0]             pend;
  logic [rsis_pkg::CNT_W-1:0] cnt;
  logic [rsis_pkg::CNT_W-1:0] step_len;
  logic [rsis_pkg::CNT_W-1:0] stable_cnt;
  logic                   motor_on;
  logic                   cal_done;
  logic                   full_speed;
  logic                   allowed_q;
  logic                   run_pulse;
  logic [7:0]             prog_num;

  assign raw_pins = {AUTO_ENABLE_I, PREP_START_I, MOTOR_REQ_I, CAL_REQ_I, FULL_SPEED_REQUEST_I,
                     EXT_MODE_REQ_I, PROG_RESET_REQ_I, CLEAR_FAIL_I, PROG_START_I,
                     PROG_PARITY_I, PROG_SEL_I};
  assign pins = rsis_pkg::rsis_pins_t'(deb_pins);

  // Three-stage synchroniser and debounce per contact
  for (genvar i = 0; i < PIN_W; i++) begin : g_cond
    logic s1, s2, s3, deb;
    logic [rsis_pkg::CNT_W-1:0] dcnt;
    always_ff @(posedge SYS_CLK_I) begin
      if (!RST_B_I) begin
        {s1, s2, s3, deb} <= 4'h0;
        dcnt              <= '0;
      end else begin
        s1 <= raw_pins[i];
        s2 <= s1;
        s3 <= s2;
        if ((s2 == s3) && (s3 != deb)) begin
          dcnt <= dcnt + 1'b1;
          if (dcnt == rsis_pkg::CNT_W'(rsis_pkg::DEB_CYC - 1)) begin
            deb  <= s3;
            dcnt <= '0;
          end
        end else begin
          dcnt <= '0;
        end
      end
    end
    assign deb_pins[i] = deb;
  end

  // APB decode
  wire apb_acc   = PSEL_I & PENABLE_I;
  wire hit_ctrl  = (PADDR_I == rsis_pkg::CTRL_OFF);
  wire hit_stat  = (PADDR_I == rsis_pkg::STATUS_OFF);
  wire hit_err   = (PADDR_I == rsis_pkg::ERROR_OFF);
  wire hit_prog  = (PADDR_I == rsis_pkg::PROG_OFF);
  wire hit_cmd   = (PADDR_I == rsis_pkg::CMD_OFF);
  wire mapped    = hit_ctrl | hit_stat | hit_err | hit_prog | hit_cmd;
  wire wr_fire   = apb_acc & PREADY_O & PWRITE_I & mapped;
  wire cmd_wr    = wr_fire & hit_cmd;
  wire cmd_man   = cmd_wr & PWDATA_I[rsis_pkg::CMD_MANUAL_BIT];
  wire cmd_clr   = cmd_wr & PWDATA_I[rsis_pkg::CMD_CLEAR_BIT];
  wire [31:0] stat_word = {23'h000000, (mode <= rsis_pkg::MD_TEACH) & !pins.auto_enable,
                           seq != rsis_pkg::SQ_IDLE, seq == rsis_pkg::SQ_PRST, full_speed,
                           cal_done, motor_on, pins.auto_enable, mode};
  wire [31:0] rd_word   = hit_ctrl ? {29'h00000000, pendant, sel} :
                          hit_stat ? stat_word :
                          hit_err  ? {15'h0000, err} :
                          hit_prog ? {24'h000000, prog_num} : 32'h00000000;

  // APB answer, one wait state
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= 32'h00000000;
    end else begin
      PREADY_O  <= apb_acc & !PREADY_O;
      PSLVERR_O <= apb_acc & !PREADY_O & !mapped;
      PRDATA_O  <= (apb_acc & !PREADY_O & !PWRITE_I) ? rd_word : 32'h00000000;
    end
  end

  // Control register
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      sel     <= rsis_pkg::SEL_RST;
      pendant <= rsis_pkg::PEND_RST;
    end else if (wr_fire & hit_ctrl) begin
      sel     <= PWDATA_I[rsis_pkg::CTRL_SEL_LSB +: 2];
      pendant <= PWDATA_I[rsis_pkg::CTRL_PENDANT_BIT];
    end
  end

  // Mode qualification
  wire en        = pins.auto_enable;
  wire is_auto   = (mode == rsis_pkg::MD_INT_AUTO) | (mode == rsis_pkg::MD_EXT_AUTO);
  wire is_ext    = (mode == rsis_pkg::MD_EXT_AUTO);
  wire sel_auto  = sel[1];
  wire auto_ok   = en | !pendant;
  wire allowed   = is_auto ? auto_ok : !en;
  wire prep_rise = pins.prep_start & !pins_q.prep_start;
  wire start_rise = pins.prog_start & !pins_q.prog_start;

  // Program start checks
  wire par_ok    = ^{pins.prog_parity, pins.prog_sel};
  wire range_ok  = (pins.prog_sel <= 8'(rsis_pkg::PROG_MAX));
  wire word_chg  = ({pins.prog_parity, pins.prog_sel} != {pins_q.prog_parity, pins_q.prog_sel});
  wire early     = word_chg | (stable_cnt < rsis_pkg::CNT_W'(HOLD_CYC));
  wire ev_mode   = start_rise & !is_ext;
  wire ev_early  = start_rise & is_ext & pendant & early;
  wire ev_par    = start_rise & is_ext & pendant & !early & !par_ok;
  wire ev_range  = start_rise & is_ext & pendant & !early & par_ok & !range_ok;
  wire run_ok    = start_rise & is_ext & pendant & !early & par_ok & range_ok;

  // Mode error events
  wire clr_req   = (prep_rise & pins.clear_fail) | cmd_clr;
  wire lost_held = err.valid & (err.code == rsis_pkg::ERR_AUTO_LOST) & !clr_req;
  wire ev_f3     = sel_auto & !en & pendant & !lost_held;
  wire ev_fc     = is_auto & !auto_ok;
  wire ev_fd     = allowed_q & !allowed & !ev_fc;
  wire ev_f2     = cmd_man & en & !is_auto;

  // Sequencer step qualification
  wire go_ext    = (seq == rsis_pkg::SQ_EXT) & pend[3] & motor_on & cal_done
                   & pendant & is_auto & auto_ok;
  wire step_act  = (seq == rsis_pkg::SQ_MOTOR) ? pend[0] & is_auto :
                   (seq == rsis_pkg::SQ_CAL)   ? pend[1] & motor_on :
                   (seq == rsis_pkg::SQ_PRST)  ? pend[4] : 1'b0;
  wire step_done = !step_act | (cnt == step_len - 1'b1);
  assign step_len = (seq == rsis_pkg::SQ_MOTOR) ? rsis_pkg::CNT_W'(rsis_pkg::MOTOR_CYC) :
                    (seq == rsis_pkg::SQ_CAL)   ? rsis_pkg::CNT_W'(rsis_pkg::CAL_CYC) :
                    (seq == rsis_pkg::SQ_PRST)  ? rsis_pkg::CNT_W'(PRST_CYC) :
                    rsis_pkg::CNT_W'(1);

  // Sequencer next step, one sub-command at a time
  always_comb begin
    next_seq = seq;
    case (seq)
      rsis_pkg::SQ_IDLE:  if (prep_rise) next_seq = rsis_pkg::SQ_MOTOR;
      rsis_pkg::SQ_MOTOR: if (step_done) next_seq = rsis_pkg::SQ_CAL;
      rsis_pkg::SQ_CAL:   if (step_done) next_seq = rsis_pkg::SQ_SPEED;
      rsis_pkg::SQ_SPEED: next_seq = rsis_pkg::SQ_EXT;
      rsis_pkg::SQ_EXT:   next_seq = rsis_pkg::SQ_PRST;
      rsis_pkg::SQ_PRST:  if (step_done) next_seq = rsis_pkg::SQ_IDLE;
      default:            next_seq = rsis_pkg::SQ_IDLE;
    endcase
  end

  // Mode next value
  always_comb begin
    next_mode = mode;
    if (ev_fc) begin
      next_mode = rsis_pkg::MD_MANUAL;
    end else if (ev_early) begin
      next_mode = rsis_pkg::MD_INT_AUTO;
    end else if (go_ext) begin
      next_mode = rsis_pkg::MD_EXT_AUTO;
    end else if (!sel_auto) begin
      next_mode = rsis_pkg::rsis_mode_t'(sel);
    end else if (!is_auto && auto_ok) begin
      next_mode = rsis_pkg::MD_INT_AUTO;
    end
  end

  // Error next value, a new event beats a clear
  always_comb begin
    next_err = err;
    if (ev_fc) begin
      next_err = '{1'b1, rsis_pkg::ERR_AUTO_LOST};
    end else if (ev_f3) begin
      next_err = '{1'b1, rsis_pkg::ERR_AUTO_OPEN};
    end else if (ev_early) begin
      next_err = '{1'b1, rsis_pkg::ERR_SEL_EARLY};
    end else if (ev_mode) begin
      next_err = '{1'b1, rsis_pkg::ERR_SEL_MODE};
    end else if (ev_par) begin
      next_err = '{1'b1, rsis_pkg::ERR_SEL_PARITY};
    end else if (ev_range) begin
      next_err = '{1'b1, rsis_pkg::ERR_SEL_RANGE};
    end else if (ev_fd) begin
      next_err = '{1'b1, rsis_pkg::ERR_RESTRICT};
    end else if (ev_f2) begin
      next_err = '{1'b1, rsis_pkg::ERR_MAN_SHORT};
    end else if (clr_req) begin
      next_err = '{1'b0, rsis_pkg::ERR_NONE};
    end
  end

  // Core state
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      pins_q    <= '0;
      mode      <= rsis_pkg::MD_MANUAL;
      seq       <= rsis_pkg::SQ_IDLE;
      err       <= '0;
      allowed_q <= 1'b1;
      pend      <= 5'h00;
      cnt       <= '0;
    end else begin
      pins_q    <= pins;
      mode      <= next_mode;
      seq       <= next_seq;
      err       <= next_err;
      allowed_q <= allowed;
      cnt       <= (next_seq != seq) ? '0 : cnt + 1'b1;
      if (prep_rise && (seq == rsis_pkg::SQ_IDLE)) begin
        pend <= {pins.prog_reset_req, pins.ext_mode_req, pins.full_speed_request,
                 pins.cal_req, pins.motor_req};
      end
    end
  end

  // Motor, calibration and speed state
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      motor_on   <= 1'b0;
      cal_done   <= 1'b0;
      full_speed <= 1'b0;
    end else begin
      if (ev_mode | ev_early) begin
        motor_on <= 1'b0;
      end else if ((seq == rsis_pkg::SQ_MOTOR) && step_act && step_done) begin
        motor_on <= 1'b1;
      end
      if ((seq == rsis_pkg::SQ_CAL) && step_act && step_done) begin
        cal_done <= 1'b1;
      end
      if ((seq == rsis_pkg::SQ_SPEED) && pend[2]) begin
        full_speed <= 1'b1;
      end
    end
  end

  // Program number stability and launch
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      stable_cnt <= '0;
      prog_num   <= 8'h00;
      run_pulse  <= 1'b0;
    end else begin
      if (word_chg) begin
        stable_cnt <= '0;
      end else if (early) begin
        stable_cnt <= stable_cnt + 1'b1;
      end
      run_pulse <= run_ok;
      if (run_ok) begin
        prog_num <= pins.prog_sel;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      POWER_ON_COMPLETE_O <= 1'b0;
      AUTO_MODE_O         <= 1'b0;
      EXT_MODE_O          <= 1'b0;
      MANUAL_OK_O         <= 1'b0;
      MOTOR_ON_O          <= 1'b0;
      CAL_DONE_O          <= 1'b0;
      FULL_SPEED_O        <= 1'b0;
      PROG_INIT_O         <= 1'b0;
      PROG_RUN_O          <= 1'b0;
      PROG_NUM_O          <= 8'h00;
      ERROR_VALID_O       <= 1'b0;
      ERROR_CODE_O        <= rsis_pkg::ERR_NONE;
    end else begin
      POWER_ON_COMPLETE_O <= 1'b1;
      AUTO_MODE_O         <= is_auto;
      EXT_MODE_O          <= is_ext & auto_ok;
      MANUAL_OK_O         <= !is_auto & !en;
      MOTOR_ON_O          <= motor_on;
      CAL_DONE_O          <= cal_done;
      FULL_SPEED_O        <= full_speed;
      PROG_INIT_O         <= (seq == rsis_pkg::SQ_PRST) & pend[4];
      PROG_RUN_O          <= run_pulse;
      PROG_NUM_O          <= prog_num;
      ERROR_VALID_O       <= err.valid;
      ERROR_CODE_O        <= err.code;
    end
  end

  // Checks
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_B_I);

  sequence s_start_ext;
    start_rise && is_ext && pendant;
  endsequence

  sequence s_launch;
    ##2 PROG_RUN_O;
  endsequence

  auto_blocked_a: assert property (is_auto && !auto_ok |=> !is_auto)
    else $error("auto mode kept with enable open");
  auto_lost_a: assert property (ev_fc |=> err.code == rsis_pkg::ERR_AUTO_LOST)
    else $error("auto loss did not raise 21FC");
  auto_open_err_a: assert property (ev_f3 [*3] |=> ##1 ERROR_CODE_O == rsis_pkg::ERR_AUTO_OPEN)
    else $error("21F3 not held");
  ext_drop_a: assert property (is_ext && $fell(en) && pendant |=> ##1 !EXT_MODE_O)
    else $error("external mode output not dropped");
  cal_gate_a: assert property (seq == rsis_pkg::SQ_CAL && !motor_on |=> !cal_done || $past(cal_done))
    else $error("calibration without motor power");
  ext_gate_a: assert property ($rose(is_ext) |-> $past(motor_on) && $past(cal_done))
    else $error("external mode entered without power and calibration");
  speed_set_a: assert property (seq == rsis_pkg::SQ_SPEED && pend[2] |=> ##1 FULL_SPEED_O)
    else $error("full speed not set");
  wrong_mode_a: assert property (ev_mode |=> ##1 !MOTOR_ON_O && ERROR_VALID_O)
    else $error("program select outside external mode accepted");
  launch_ok_a: assert property (s_start_ext and (!early && par_ok && range_ok) |-> s_launch)
    else $error("valid start did not launch");
  launch_check_a: assert property (PROG_RUN_O |-> ^{$past(pins.prog_parity, 2), PROG_NUM_O}
                                   && PROG_NUM_O <= 8'h7F)
    else $error("launched program has bad parity or range");
  clear_err_a: assert property (clr_req && !(ev_f3 || ev_fc || ev_fd || ev_f2 || start_rise)
                                |=> !err.valid)
    else $error("error not cleared");

endmodule : rsis_sequencer

// *** core/rsis_pkg.sv ***
package rsis_pkg;

  // Clock and times
  localparam int CLK_HZ         = 10_000_000;
  localparam int DEB_TIME_US    = 100;
  localparam int DEB_CYC        = (DEB_TIME_US * (CLK_HZ / 1_000_000));
  localparam int HOLD_TIME_MS   = 1;
  localparam int HOLD_CYC_DEF   = (HOLD_TIME_MS * (CLK_HZ / 1000));
  localparam int PRST_TIME_MS   = 1000;
  localparam int PRST_CYC_DEF   = (PRST_TIME_MS * (CLK_HZ / 1000));
  localparam int MOTOR_TIME_US  = 100;
  localparam int MOTOR_CYC      = (MOTOR_TIME_US * (CLK_HZ / 1_000_000));
  localparam int CAL_TIME_US    = 200;
  localparam int CAL_CYC        = (CAL_TIME_US * (CLK_HZ / 1_000_000));
  localparam int CNT_W          = 24;
  localparam int PROG_MAX       = 127;

  // Register offsets
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] ERROR_OFF  = 8'h08;
  localparam logic [7:0] PROG_OFF   = 8'h0C;
  localparam logic [7:0] CMD_OFF    = 8'h10;

  // Field positions and reset values
  localparam int CTRL_SEL_LSB     = 0;
  localparam int CTRL_PENDANT_BIT = 2;
  localparam int CMD_MANUAL_BIT   = 0;
  localparam int CMD_CLEAR_BIT    = 1;
  localparam int ERR_VALID_BIT    = 16;
  localparam logic [1:0] SEL_RST  = 2'h0;
  localparam logic       PEND_RST = 1'b1;

  // Error codes
  localparam logic [15:0] ERR_AUTO_LOST  = 16'h21FC;
  localparam logic [15:0] ERR_RESTRICT   = 16'h21FD;
  localparam logic [15:0] ERR_MAN_SHORT  = 16'h21F2;
  localparam logic [15:0] ERR_AUTO_OPEN  = 16'h21F3;
  localparam logic [15:0] ERR_SEL_MODE   = 16'h21E2;
  localparam logic [15:0] ERR_SEL_PARITY = 16'h21E4;
  localparam logic [15:0] ERR_SEL_RANGE  = 16'h21E6;
  localparam logic [15:0] ERR_SEL_EARLY  = 16'h2031;
  localparam logic [15:0] ERR_NONE       = 16'h0000;

  // Operation modes, selector uses the same order
  typedef enum logic [1:0] {MD_MANUAL, MD_TEACH, MD_INT_AUTO, MD_EXT_AUTO} rsis_mode_t;

  // Preparation sequencer steps
  typedef enum logic [2:0] {SQ_IDLE, SQ_MOTOR, SQ_CAL, SQ_SPEED, SQ_EXT, SQ_PRST} rsis_seq_t;

  // Conditioned contact inputs
  typedef struct packed {
    logic       auto_enable;
    logic       prep_start;
    logic       motor_req;
    logic       cal_req;
    logic       full_speed_request;
    logic       ext_mode_req;
    logic       prog_reset_req;
    logic       clear_fail;
    logic       prog_start;
    logic       prog_parity;
    logic [7:0] prog_sel;
  } rsis_pins_t;

  // Latched error
  typedef struct packed {
    logic        valid;
    logic [15:0] code;
  } rsis_err_t;

endpackage : rsis_pkg

// *** verification/rsis_plc_model.sv ***
`timescale 1ns/100ps
module rsis_plc_model (
  // Clock and power-on status
  input  wire logic            clk_i,
  input  wire logic            pwr_ok_i,
  // Contact levels, high is shorted
  output rsis_pkg::rsis_pins_t pins_o
);
  // Past sync, debounce and hold time
  localparam int SETTLE = rsis_pkg::DEB_CYC + 30;
  // Contacts start open
  initial pins_o = '0;
  // Drive a pattern once power-on is complete
  task automatic apply(input rsis_pkg::rsis_pins_t p);
    int k;
    for (k = 0; k < 100 && pwr_ok_i !== 1'b1; k++) @(posedge clk_i);
    @(posedge clk_i);
    pins_o <= p;
    repeat (SETTLE) @(posedge clk_i);
  endtask : apply
  // Number word with odd parity, optionally spoiled
  function automatic rsis_pkg::rsis_pins_t word(input rsis_pkg::rsis_pins_t p,
                                                input logic [7:0] n, input logic bad);
    word = p;
    word.prog_sel = n;
    word.prog_parity = ~(^n) ^ bad;
  endfunction : word
endmodule : rsis_plc_model

// *** verification/testbench.sv ***
`timescale 1ns/100ps
`define CHK(a, b) check_val(32'(a), 32'(b))
`define WAITC(c, n) for (wk = 0; wk < n && !(c); wk++) @(posedge SYS_CLK_I); if (!(c)) hang();
module testbench;
  // Clock, reset and bus
  logic        SYS_CLK_I = 0, RST_B_I = 0;
  logic        PSEL_I = 0, PENABLE_I = 0, PWRITE_I = 0;
  logic [7:0]  PADDR_I = '0;
  logic [31:0] PWDATA_I = '0, PRDATA_O, rd;
  logic        PREADY_O, PSLVERR_O, err;
  // Status outputs
  logic        POWER_ON_COMPLETE_O, AUTO_MODE_O, EXT_MODE_O, MANUAL_OK_O, MOTOR_ON_O;
  logic        CAL_DONE_O, FULL_SPEED_O, PROG_INIT_O, PROG_RUN_O, ERROR_VALID_O;
  logic [7:0]  PROG_NUM_O, run_num = '0;
  logic [15:0] ERROR_CODE_O;
  // Contacts and bookkeeping
  rsis_pkg::rsis_pins_t pins, p;
  int          failures = 0, cmp_count = 0, run_cnt = 0, wk;
  always #50 SYS_CLK_I = ~SYS_CLK_I;
  rsis_sequencer #(.HOLD_CYC(20), .PRST_CYC(20)) DUT (
    .SYS_CLK_I(SYS_CLK_I), .RST_B_I(RST_B_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .AUTO_ENABLE_I(pins.auto_enable),
    .PREP_START_I(pins.prep_start), .MOTOR_REQ_I(pins.motor_req), .CAL_REQ_I(pins.cal_req),
    .FULL_SPEED_REQUEST_I(pins.full_speed_request), .EXT_MODE_REQ_I(pins.ext_mode_req),
    .PROG_RESET_REQ_I(pins.prog_reset_req), .CLEAR_FAIL_I(pins.clear_fail),
    .PROG_START_I(pins.prog_start), .PROG_PARITY_I(pins.prog_parity),
    .PROG_SEL_I(pins.prog_sel), .POWER_ON_COMPLETE_O(POWER_ON_COMPLETE_O),
    .AUTO_MODE_O(AUTO_MODE_O), .EXT_MODE_O(EXT_MODE_O), .MANUAL_OK_O(MANUAL_OK_O),
    .MOTOR_ON_O(MOTOR_ON_O), .CAL_DONE_O(CAL_DONE_O), .FULL_SPEED_O(FULL_SPEED_O),
    .PROG_INIT_O(PROG_INIT_O), .PROG_RUN_O(PROG_RUN_O), .PROG_NUM_O(PROG_NUM_O),
    .ERROR_VALID_O(ERROR_VALID_O), .ERROR_CODE_O(ERROR_CODE_O));
  rsis_plc_model plc (.clk_i(SYS_CLK_I), .pwr_ok_i(POWER_ON_COMPLETE_O), .pins_o(pins));
  // Count launched program cycles
  always @(posedge SYS_CLK_I) if (PROG_RUN_O === 1'b1) begin
    run_cnt <= run_cnt + 1;
    run_num <= PROG_NUM_O;
  end
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  task automatic hang;
    failures++;
    report_and_stop();
  endtask : hang
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      failures++;
    end
  endtask : check_val
  // One APB transfer, answer taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge SYS_CLK_I);
    {PSEL_I, PENABLE_I, PWRITE_I, PADDR_I, PWDATA_I} <= {1'b1, 1'b0, w, a, d};
    @(posedge SYS_CLK_I);
    PENABLE_I <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge SYS_CLK_I);
      if (PREADY_O === 1'b1) break;
    end
    if (k == 20) hang();
    rd = PRDATA_O;
    err = PSLVERR_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
  endtask : apb
  task automatic clear_err;
    apb(1'b1, rsis_pkg::CMD_OFF, 32'h2);
    `WAITC(ERROR_VALID_O === 1'b0, 20)
  endtask : clear_err
  task automatic wait_err;
    `WAITC(ERROR_VALID_O === 1'b1, 50)
  endtask : wait_err
  task automatic start_prog(input logic [7:0] n, input logic bad);
    p = plc.word(p, n, bad);
    plc.apply(p);
    p.prog_start = 1'b1;
    plc.apply(p);
    p.prog_start = 1'b0;
    plc.apply(p);
  endtask : start_prog
  task automatic t_reset;
    `CHK(POWER_ON_COMPLETE_O, 1);
    `CHK(MANUAL_OK_O, 1);
    apb(1'b0, rsis_pkg::STATUS_OFF, '0);
    `CHK(rd, 32'h00000100);
    apb(1'b0, 8'h20, '0);
    `CHK(err, 1);
    `CHK(rd, 0);
  endtask : t_reset
  task automatic t_mode;
    apb(1'b1, rsis_pkg::CTRL_OFF, 32'h6);
    wait_err();
    `CHK(ERROR_CODE_O, rsis_pkg::ERR_AUTO_OPEN);
    `CHK(AUTO_MODE_O, 0);
    apb(1'b1, rsis_pkg::CMD_OFF, 32'h2);
    repeat (5) @(posedge SYS_CLK_I);
    `CHK(ERROR_VALID_O, 1);
    p.auto_enable = 1'b1;
    plc.apply(p);
    `CHK(AUTO_MODE_O, 1);
    clear_err();
    apb(1'b1, rsis_pkg::CTRL_OFF, 32'h4);
    wait_err();
    `CHK(ERROR_CODE_O, rsis_pkg::ERR_RESTRICT);
    `CHK(MANUAL_OK_O, 0);
    clear_err();
    apb(1'b1, rsis_pkg::CMD_OFF, 32'h1);
    wait_err();
    `CHK(ERROR_CODE_O, rsis_pkg::ERR_MAN_SHORT);
    apb(1'b0, rsis_pkg::ERROR_OFF, '0);
    `CHK(rd, {15'h0000, 1'b1, rsis_pkg::ERR_MAN_SHORT});
    clear_err();
    apb(1'b1, rsis_pkg::CTRL_OFF, 32'h7);
    repeat (5) @(posedge SYS_CLK_I);
    `CHK(ERROR_VALID_O, 0);
  endtask : t_mode
  task automatic t_prep;
    {p.motor_req, p.cal_req, p.full_speed_request, p.ext_mode_req, p.prog_reset_req} = '1;
    plc.apply(p);
    p.prep_start = 1'b1;
    plc.apply(p);
    `WAITC(CAL_DONE_O === 1'b1, 4000)
    `CHK(MOTOR_ON_O, 1);
    `WAITC(EXT_MODE_O === 1'b1, 100)
    `CHK({MOTOR_ON_O, CAL_DONE_O}, 2'h3);
    `CHK(FULL_SPEED_O, 1);
    `CHK(EXT_MODE_O, 1);
    `WAITC(PROG_INIT_O === 1'b1, 100)
    `CHK(PROG_INIT_O, 1);
    {p.motor_req, p.cal_req, p.full_speed_request, p.ext_mode_req} = '0;
    {p.prog_reset_req, p.prep_start} = '0;
    plc.apply(p);
  endtask : t_prep
  task automatic t_prog;
    int i;
    start_prog(8'h0F, 1'b0);
    `CHK({run_cnt[7:0], run_num}, 16'h010F);
    `CHK(ERROR_VALID_O, 0);
    apb(1'b0, rsis_pkg::PROG_OFF, '0);
    `CHK(rd, 32'h0000000F);
    for (i = 0; i < 2; i++) begin
      start_prog(i ? 8'hC8 : 8'h1A, i == 0);
      `CHK(ERROR_CODE_O, i ? rsis_pkg::ERR_SEL_RANGE : rsis_pkg::ERR_SEL_PARITY);
      `CHK(run_cnt, 1);
      clear_err();
    end
    // Number and start change together: too early
    p = plc.word(p, 8'h05, 1'b0);
    p.prog_start = 1'b1;
    plc.apply(p);
    `CHK(ERROR_CODE_O, rsis_pkg::ERR_SEL_EARLY);
    `CHK({AUTO_MODE_O, EXT_MODE_O, MOTOR_ON_O, run_cnt[1:0]}, 5'h11);
    clear_err();
    // Back to external mode with motor power
    {p.prog_start, p.motor_req, p.ext_mode_req} = 3'h3;
    plc.apply(p);
    p.prep_start = 1'b1;
    plc.apply(p);
    `WAITC(EXT_MODE_O === 1'b1, 1500)
    `CHK({EXT_MODE_O, MOTOR_ON_O}, 2'h3);
    {p.motor_req, p.ext_mode_req, p.prep_start} = '0;
    plc.apply(p);
  endtask : t_prog
  task automatic t_lost;
    p.auto_enable = 1'b0;
    plc.apply(p);
    `CHK({EXT_MODE_O, ERROR_VALID_O}, 2'h1);
    `CHK(AUTO_MODE_O, 0);
    `CHK(ERROR_CODE_O, rsis_pkg::ERR_AUTO_LOST);
    apb(1'b1, rsis_pkg::CTRL_OFF, 32'h4);
    clear_err();
    start_prog(8'h0F, 1'b0);
    `CHK(ERROR_CODE_O, rsis_pkg::ERR_SEL_MODE);
    `CHK({run_cnt[7:0], MOTOR_ON_O}, 9'h002);
    {p.clear_fail, p.prep_start} = 2'h3;
    plc.apply(p);
    `CHK(ERROR_VALID_O, 0);
  endtask : t_lost
  // Reset, scenarios, verdict
  initial begin
    p = '0;
    repeat (8) @(posedge SYS_CLK_I);
    RST_B_I <= 1'b1;
    repeat (2) @(posedge SYS_CLK_I);
    t_reset();
    t_mode();
    t_prep();
    t_prog();
    t_lost();
    report_and_stop();
  end
  // Hang guard
  initial begin
    repeat (90000) @(posedge SYS_CLK_I);
    hang();
  end
endmodule : testbench
